// ===== rtl/dols_defs.svh
`ifndef DOLS_DEFS_SVH
`define DOLS_DEFS_SVH

// Lower-half selector codes
`define DOLS_LO_RESET      5'h00
`define DOLS_LO_I8         5'h03
`define DOLS_LO_I8_SIDE    5'h04
`define DOLS_LO_I8_X2      5'h05
`define DOLS_LO_I7         5'h09
`define DOLS_LO_I6         5'h0D
`define DOLS_LO_I6_SIDE    5'h0E
`define DOLS_LO_I6_X2      5'h0F
`define DOLS_LO_I6_X4      5'h10
`define DOLS_LO_I16        5'h11
`define DOLS_LO_I16_X2     5'h12
`define DOLS_LO_BF16       5'h13
`define DOLS_LO_BF16_X2    5'h14
`define DOLS_LO_BF16_ALT   5'h15
`define DOLS_LO_FP16       5'h16
`define DOLS_LO_FP16_X2    5'h17
`define DOLS_LO_FP16_ALT   5'h18
`define DOLS_LO_FP24       5'h19
`define DOLS_LO_FP24_X2    5'h1A
`define DOLS_LO_I7_X2      5'h1B
`define DOLS_LO_I7_X4      5'h1C

// Upper-half selector codes beyond the shared ones
`define DOLS_HI_RESET      6'h00
`define DOLS_HI_I8_6       6'h23
`define DOLS_HI_I8_SIDE8   6'h24
`define DOLS_HI_I8_X4      6'h25
`define DOLS_HI_I7_X2S     6'h29
`define DOLS_HI_I6_X2S     6'h2D
`define DOLS_HI_I6_SIDE2   6'h2E
`define DOLS_HI_I16_SPLIT  6'h31
`define DOLS_HI_BF16_SPLIT 6'h33
`define DOLS_HI_BF16_CMP   6'h35
`define DOLS_HI_FP16_SPLIT 6'h36
`define DOLS_HI_FP16_CMP   6'h38
`define DOLS_HI_FP24_SPLIT 6'h39
`define DOLS_HI_FP24_CMP   6'h3A

// Mantissa width field encodings
`define DOLS_MW_8          3'b000
`define DOLS_MW_16         3'b001
`define DOLS_MW_3          3'b011
`define DOLS_MW_4          3'b100
`define DOLS_MW_6          3'b110
`define DOLS_MW_7          3'b111

// Operand lane positions
`define DOLS_L16_0_LSB     0
`define DOLS_L16_1_LSB     16
`define DOLS_L16_2_LSB     32
`define DOLS_L16_3_LSB     48
`define DOLS_L24_0_LSB     0
`define DOLS_L24_1_LSB     24
`define DOLS_L24_2_LSB     48

// Value 1.0 in 24-bit float: sign 0, biased exponent 127, mantissa 0
`define DOLS_FP24_ONE      24'h3F8000
`define DOLS_EXP_RESET     8'h00

`endif

// ===== rtl/dols_pkg.sv
package dols_pkg;

    // Operand arrangement selected by both halves together
    typedef enum logic [3:0] {
        DOLS_LAY_NONE     = 4'h0,
        DOLS_LAY_SHARED   = 4'h1,
        DOLS_LAY_F16_ONE  = 4'h2,
        DOLS_LAY_F16_SPL  = 4'h3,
        DOLS_LAY_F16_X2   = 4'h4,
        DOLS_LAY_F16_ALT  = 4'h5,
        DOLS_LAY_F16_CMP  = 4'h6,
        DOLS_LAY_F24_ONE  = 4'h7,
        DOLS_LAY_F24_SPL  = 4'h8,
        DOLS_LAY_F24_X2   = 4'h9,
        DOLS_LAY_F24_CMP  = 4'hA
    } dols_layout_t;

    typedef enum logic [2:0] {
        DOLS_W8  = 3'b000,
        DOLS_W16 = 3'b001,
        DOLS_W3  = 3'b011,
        DOLS_W4  = 3'b100,
        DOLS_W6  = 3'b110,
        DOLS_W7  = 3'b111
    } dols_width_t;

endpackage : dols_pkg

// ===== rtl/dols_unit_cfg.sv
`include "dols_defs.svh"

// Per product unit: registers the enable and width field, flags legality
module dols_unit_cfg
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Configuration
    input  wire logic        shared_exponent_enable_i,
    input  wire logic [2:0]  mantissa_width_field_i,
    // Registered state
    output logic             shared_mode_o,
    output dols_pkg::dols_width_t width_o,
    output logic             width_valid_o
);
    import dols_pkg::*;

    logic        shared_q;
    dols_width_t width_q;
    logic        valid_q;

    function automatic logic width_legal(input logic [2:0] w);
        case (w)
            `DOLS_MW_8, `DOLS_MW_16, `DOLS_MW_3,
            `DOLS_MW_4, `DOLS_MW_6, `DOLS_MW_7: width_legal = 1'b1;
            default:                            width_legal = 1'b0;
        endcase
    endfunction : width_legal

    // Enable 0 means ordinary float, 1 means shared exponent
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shared_q <= 1'b0;
        end else begin
            shared_q <= shared_exponent_enable_i;
        end
    end

    // Unlisted widths fall back to 8x8 and raise the flag low
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            width_q <= DOLS_W8;
            valid_q <= 1'b1;
        end else begin
            valid_q <= width_legal(mantissa_width_field_i);
            width_q <= width_legal(mantissa_width_field_i) ? dols_width_t'(mantissa_width_field_i) : DOLS_W8;
        end
    end

    assign shared_mode_o = shared_q;
    assign width_o       = width_q;
    assign width_valid_o = valid_q;

    property p_width_track;
        @(posedge clk_i) disable iff (!reset_n_i)
        width_legal(mantissa_width_field_i) |=> (width_o == $past(mantissa_width_field_i));
    endproperty
    a_width_track: assert property (p_width_track) else $error("width field not taken");

    property p_enable_track;
        @(posedge clk_i) disable iff (!reset_n_i)
        shared_exponent_enable_i |=> shared_mode_o;
    endproperty
    a_enable_track: assert property (p_enable_track) else $error("shared enable not taken");

endmodule : dols_unit_cfg

// ===== rtl/dols_lane_select.sv
`include "dols_defs.svh"

// How it works
// - Lower selector decodes 8-bit shared codes 03, 04, 05.
// - Lower selector decodes 7- and 6-bit codes; resets to 00.
// - Upper selector takes shared codes plus each with bit 5 set (23, 24, 25, 29, 2D, 2E, 31 and the rest).
// - First unit: enable 0 ordinary float, 1 shared exponent; default 0.
// - Second unit likewise with its own independent enable.
// - First width field picks 8,16,3,4,6,7-bit multipliers; default 000.
// - Second width field uses same encoding, set independently.
// - Two product units: a times b, and c times d.
// - Three-operand modes force d to 1.0.
// - Shared mode scales each group by its two shared exponents.
module dols_lane_select
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Selector settings
    input  wire logic [4:0]  lower_select_i,
    input  wire logic [5:0]  upper_select_i,
    input  wire logic        first_shared_exponent_enable_i,
    input  wire logic [2:0]  first_mantissa_width_field_i,
    input  wire logic        second_shared_exponent_enable_i,
    input  wire logic [2:0]  second_mantissa_width_field_i,
    // Operand buses and side exponent
    input  wire logic [71:0] mult_a_low_i,
    input  wire logic [71:0] mult_b_low_i,
    input  wire logic [71:0] mult_a_high_i,
    input  wire logic [71:0] mult_b_high_i,
    input  wire logic [7:0]  side_exponent_i,
    // Selected operands to product units
    output logic [23:0]      first_op_a_o,
    output logic [23:0]      first_op_b_o,
    output logic [23:0]      second_op_c_o,
    output logic [23:0]      second_op_d_o,
    output logic             d_forced_one_o,
    output logic             narrow_exp_o,
    // Shared-exponent controls
    output logic             first_shared_mode_o,
    output logic             second_shared_mode_o,
    output dols_pkg::dols_width_t first_width_o,
    output dols_pkg::dols_width_t second_width_o,
    output logic [7:0]       shared_exp_ea_o,
    output logic [7:0]       shared_exp_eb_o,
    output logic [7:0]       shared_exp_ec_o,
    output logic [7:0]       shared_exp_ed_o,
    // Status
    output dols_pkg::dols_layout_t layout_o,
    output logic             select_valid_o
);
    import dols_pkg::*;

    // ****************************************************************
    // Decode
    // ****************************************************************
    dols_layout_t lay_d, lay_q;
    logic         side_eb_d, side_ed_d;
    logic         narrow_d;

    function automatic logic [23:0] lane16(input logic [71:0] bus, input int lsb);
        lane16 = {bus[lsb +: 16], 8'h00};
    endfunction : lane16

    function automatic logic lo_shared(input logic [4:0] s);
        case (s)
            `DOLS_LO_I8, `DOLS_LO_I8_SIDE, `DOLS_LO_I8_X2, `DOLS_LO_I7,
            `DOLS_LO_I6, `DOLS_LO_I6_SIDE, `DOLS_LO_I6_X2, `DOLS_LO_I6_X4,
            `DOLS_LO_I7_X2, `DOLS_LO_I7_X4, `DOLS_LO_I16, `DOLS_LO_I16_X2: lo_shared = 1'b1;
            default: lo_shared = 1'b0;
        endcase
    endfunction : lo_shared

    always_comb begin
        lay_d     = DOLS_LAY_NONE;
        side_eb_d = 1'b0;
        side_ed_d = 1'b0;
        narrow_d  = 1'b0;
        if (lo_shared(lower_select_i) &&
            ((upper_select_i == {1'b0, lower_select_i}) ||
             (upper_select_i == {1'b1, lower_select_i}))) begin
            lay_d     = DOLS_LAY_SHARED;
            side_eb_d = (lower_select_i == `DOLS_LO_I8_SIDE) || (lower_select_i == `DOLS_LO_I6_SIDE)
                     || (lower_select_i == `DOLS_LO_I16);
            side_ed_d = side_eb_d && upper_select_i[5];
        end else begin
            case ({lower_select_i, upper_select_i})
                {`DOLS_LO_BF16, 6'h13}, {`DOLS_LO_FP16, 6'h16}:   lay_d = DOLS_LAY_F16_ONE;
                {`DOLS_LO_BF16, `DOLS_HI_BF16_SPLIT},
                {`DOLS_LO_FP16, `DOLS_HI_FP16_SPLIT}:             lay_d = DOLS_LAY_F16_SPL;
                {`DOLS_LO_BF16_X2, 6'h14}, {`DOLS_LO_FP16_X2, 6'h17}: lay_d = DOLS_LAY_F16_X2;
                {`DOLS_LO_BF16_ALT, 6'h15}, {`DOLS_LO_FP16_ALT, 6'h18}: lay_d = DOLS_LAY_F16_ALT;
                {`DOLS_LO_BF16_ALT, `DOLS_HI_BF16_CMP},
                {`DOLS_LO_FP16_ALT, `DOLS_HI_FP16_CMP}:           lay_d = DOLS_LAY_F16_CMP;
                {`DOLS_LO_FP24, 6'h19}:                           lay_d = DOLS_LAY_F24_ONE;
                {`DOLS_LO_FP24, `DOLS_HI_FP24_SPLIT}:             lay_d = DOLS_LAY_F24_SPL;
                {`DOLS_LO_FP24_X2, 6'h1A}:                        lay_d = DOLS_LAY_F24_X2;
                {`DOLS_LO_FP24_X2, `DOLS_HI_FP24_CMP}:            lay_d = DOLS_LAY_F24_CMP;
                default:                                          lay_d = DOLS_LAY_NONE;
            endcase
            narrow_d = (lower_select_i == `DOLS_LO_FP16) || (lower_select_i == `DOLS_LO_FP16_X2)
                    || (lower_select_i == `DOLS_LO_FP16_ALT);
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [4:0] lo_sel_q;

    // Unlisted pairs decode to no layout; operand outputs then read zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lay_q    <= DOLS_LAY_NONE;
            lo_sel_q <= `DOLS_LO_RESET;
        end else begin
            lay_q    <= lay_d;
            lo_sel_q <= lower_select_i;
        end
    end

    logic side_eb_q, side_ed_q, narrow_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            side_eb_q <= 1'b0;
            side_ed_q <= 1'b0;
            narrow_q  <= 1'b0;
        end else begin
            side_eb_q <= side_eb_d;
            side_ed_q <= side_ed_d;
            narrow_q  <= narrow_d;
        end
    end

    logic first_wv, second_wv;

    dols_unit_cfg u_first_cfg (
        .clk_i                    (clk_i),
        .reset_n_i                (reset_n_i),
        .shared_exponent_enable_i (first_shared_exponent_enable_i),
        .mantissa_width_field_i   (first_mantissa_width_field_i),
        .shared_mode_o            (first_shared_mode_o),
        .width_o                  (first_width_o),
        .width_valid_o            (first_wv)
    );

    dols_unit_cfg u_second_cfg (
        .clk_i                    (clk_i),
        .reset_n_i                (reset_n_i),
        .shared_exponent_enable_i (second_shared_exponent_enable_i),
        .mantissa_width_field_i   (second_mantissa_width_field_i),
        .shared_mode_o            (second_shared_mode_o),
        .width_o                  (second_width_o),
        .width_valid_o            (second_wv)
    );

    // ****************************************************************
    // Operand routing
    // ****************************************************************
    logic [23:0] a_d, b_d, c_d, d_d;
    logic        one_d;

    always_comb begin
        a_d   = 24'h000000;
        b_d   = 24'h000000;
        c_d   = 24'h000000;
        d_d   = 24'h000000;
        one_d = 1'b0;
        case (lay_d)
            DOLS_LAY_F16_ONE: begin
                a_d = lane16(mult_a_low_i, `DOLS_L16_0_LSB);
                b_d = lane16(mult_b_low_i, `DOLS_L16_1_LSB);
                c_d = lane16(mult_a_high_i, `DOLS_L16_2_LSB);
                d_d = `DOLS_FP24_ONE;
                one_d = 1'b1;
            end
            DOLS_LAY_F16_SPL: begin
                a_d = lane16(mult_a_low_i, `DOLS_L16_0_LSB);
                b_d = lane16(mult_b_low_i, `DOLS_L16_1_LSB);
                c_d = lane16(mult_a_high_i, `DOLS_L16_0_LSB);
                d_d = lane16(mult_b_high_i, `DOLS_L16_1_LSB);
            end
            DOLS_LAY_F16_X2: begin
                a_d = lane16(mult_a_low_i, `DOLS_L16_0_LSB);
                b_d = lane16(mult_b_low_i, `DOLS_L16_1_LSB);
                c_d = lane16(mult_a_high_i, `DOLS_L16_2_LSB);
                d_d = lane16(mult_b_high_i, `DOLS_L16_3_LSB);
            end
            DOLS_LAY_F16_ALT: begin
                a_d = lane16(mult_a_low_i, `DOLS_L16_0_LSB);
                b_d = lane16(mult_b_low_i, `DOLS_L16_0_LSB);
                c_d = lane16(mult_a_high_i, `DOLS_L16_1_LSB);
                d_d = lane16(mult_b_high_i, `DOLS_L16_1_LSB);
            end
            DOLS_LAY_F16_CMP: begin
                a_d = lane16(mult_a_low_i, `DOLS_L16_0_LSB);
                b_d = lane16(mult_b_low_i, `DOLS_L16_0_LSB);
                c_d = lane16(mult_a_high_i, `DOLS_L16_0_LSB);
                d_d = lane16(mult_b_high_i, `DOLS_L16_0_LSB);
            end
            DOLS_LAY_F24_ONE: begin
                a_d = mult_a_low_i[`DOLS_L24_0_LSB +: 24];
                b_d = mult_b_low_i[`DOLS_L24_1_LSB +: 24];
                c_d = mult_a_high_i[`DOLS_L24_2_LSB +: 24];
                d_d = `DOLS_FP24_ONE;
                one_d = 1'b1;
            end
            DOLS_LAY_F24_SPL: begin
                a_d = mult_a_low_i[`DOLS_L24_0_LSB +: 24];
                b_d = mult_b_low_i[`DOLS_L24_1_LSB +: 24];
                c_d = mult_a_high_i[`DOLS_L24_0_LSB +: 24];
                d_d = mult_b_high_i[`DOLS_L24_1_LSB +: 24];
            end
            DOLS_LAY_F24_X2: begin
                a_d = mult_a_low_i[`DOLS_L24_0_LSB +: 24];
                b_d = mult_b_low_i[`DOLS_L24_0_LSB +: 24];
                c_d = mult_a_high_i[`DOLS_L24_1_LSB +: 24];
                d_d = mult_b_high_i[`DOLS_L24_1_LSB +: 24];
            end
            DOLS_LAY_F24_CMP: begin
                a_d = mult_a_low_i[`DOLS_L24_0_LSB +: 24];
                b_d = mult_b_low_i[`DOLS_L24_0_LSB +: 24];
                c_d = mult_a_high_i[`DOLS_L24_0_LSB +: 24];
                d_d = mult_b_high_i[`DOLS_L24_0_LSB +: 24];
            end
            default: begin
                a_d = 24'h000000;
            end
        endcase
    end

    // Product units see registered operands: a*b first, c*d second
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            first_op_a_o   <= 24'h000000;
            first_op_b_o   <= 24'h000000;
            second_op_c_o  <= 24'h000000;
            second_op_d_o  <= 24'h000000;
            d_forced_one_o <= 1'b0;
        end else begin
            first_op_a_o   <= a_d;
            first_op_b_o   <= b_d;
            second_op_c_o  <= c_d;
            second_op_d_o  <= d_d;
            d_forced_one_o <= one_d;
        end
    end

    // ****************************************************************
    // Shared exponents
    // ****************************************************************
    // Exponent byte sits at the top byte of each bus; side input replaces eb/ed
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shared_exp_ea_o <= `DOLS_EXP_RESET;
            shared_exp_eb_o <= `DOLS_EXP_RESET;
            shared_exp_ec_o <= `DOLS_EXP_RESET;
            shared_exp_ed_o <= `DOLS_EXP_RESET;
        end else begin
            shared_exp_ea_o <= mult_a_low_i[71:64];
            shared_exp_eb_o <= side_eb_d ? side_exponent_i : mult_b_low_i[71:64];
            shared_exp_ec_o <= mult_a_high_i[71:64];
            shared_exp_ed_o <= side_ed_d ? side_exponent_i : mult_b_high_i[71:64];
        end
    end

    assign layout_o       = lay_q;
    assign narrow_exp_o   = narrow_q;
    assign select_valid_o = (lay_q != DOLS_LAY_NONE) && first_wv && second_wv;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_d_one;
        @(posedge clk_i) disable iff (!reset_n_i)
        d_forced_one_o |-> (second_op_d_o == `DOLS_FP24_ONE) && (layout_o inside {DOLS_LAY_F16_ONE, DOLS_LAY_F24_ONE});
    endproperty
    a_d_one: assert property (p_d_one) else $error("d not forced to one");

    property p_f24_single;
        @(posedge clk_i) disable iff (!reset_n_i)
        (lower_select_i == `DOLS_LO_FP24 && upper_select_i == 6'h19)
        |=> (second_op_c_o == $past(mult_a_high_i[71:48])) && d_forced_one_o;
    endproperty
    a_f24_single: assert property (p_f24_single) else $error("fp24 single c lane wrong");

    property p_f16_x2;
        @(posedge clk_i) disable iff (!reset_n_i)
        (lower_select_i == `DOLS_LO_BF16_X2 && upper_select_i == 6'h14)
        |=> (second_op_d_o[23:8] == $past(mult_b_high_i[63:48]));
    endproperty
    a_f16_x2: assert property (p_f16_x2) else $error("x2 d lane wrong");

    property p_cmp;
        @(posedge clk_i) disable iff (!reset_n_i)
        (lower_select_i == `DOLS_LO_FP24_X2 && upper_select_i == `DOLS_HI_FP24_CMP)
        |=> (first_op_b_o == $past(mult_b_low_i[23:0])) && !d_forced_one_o;
    endproperty
    a_cmp: assert property (p_cmp) else $error("compact b lane wrong");

    property p_side_exp;
        @(posedge clk_i) disable iff (!reset_n_i)
        (lower_select_i == `DOLS_LO_I8_SIDE && upper_select_i == `DOLS_HI_I8_SIDE8)
        |=> (shared_exp_eb_o == $past(side_exponent_i)) && (shared_exp_ed_o == $past(side_exponent_i));
    endproperty
    a_side_exp: assert property (p_side_exp) else $error("side exponent not used");

    property p_shared_decode;
        @(posedge clk_i) disable iff (!reset_n_i)
        (lower_select_i inside {`DOLS_LO_I8_X2, `DOLS_LO_I7_X4}) && (upper_select_i == {1'b0, lower_select_i})
        |=> (layout_o == DOLS_LAY_SHARED);
    endproperty
    a_shared_decode: assert property (p_shared_decode) else $error("shared code not decoded");

    property p_upper_extra;
        @(posedge clk_i) disable iff (!reset_n_i)
        (lower_select_i == `DOLS_LO_I8 && upper_select_i == `DOLS_HI_I8_6)
        ##1 (lower_select_i == `DOLS_LO_I7 && upper_select_i == `DOLS_HI_I7_X2S)
        |=> (layout_o == DOLS_LAY_SHARED) && $stable(layout_o);
    endproperty
    a_upper_extra: assert property (p_upper_extra) else $error("upper shared code missed");

    property p_reset_sel;
        @(posedge clk_i) disable iff (!reset_n_i)
        (lo_sel_q == `DOLS_LO_RESET) |-> (layout_o == DOLS_LAY_NONE) && !select_valid_o;
    endproperty
    a_reset_sel: assert property (p_reset_sel) else $error("default selector not idle");

    property p_indep;
        @(posedge clk_i) disable iff (!reset_n_i)
        (first_shared_exponent_enable_i && !second_shared_exponent_enable_i)
        |=> first_shared_mode_o && !second_shared_mode_o;
    endproperty
    a_indep: assert property (p_indep) else $error("enables not independent");

endmodule : dols_lane_select

// ===== tb/dols_fabric_drv.sv
// Fabric side: places operands and exponents on the four buses
module dols_fabric_drv (
    // Selector pair and operands
    input  wire logic [4:0]  lower_i,
    input  wire logic [5:0]  upper_i,
    input  wire logic [23:0] a_i,
    input  wire logic [23:0] b_i,
    input  wire logic [23:0] c_i,
    input  wire logic [23:0] d_i,
    // Operand buses
    output logic      [71:0] al_o,
    output logic      [71:0] bl_o,
    output logic      [71:0] ah_o,
    output logic      [71:0] bh_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Lanes
    // ********
    logic [24:0] pos; // Float flag, then b, c, d lane LSBs; FF means d unused
    always_comb begin
        case ({lower_i, upper_i})
            {5'h13, 6'h13}, {5'h16, 6'h16}: pos = {1'b1, 8'd16, 8'd32, 8'hFF};
            {5'h13, 6'h33}, {5'h16, 6'h36}: pos = {1'b1, 8'd16, 8'd0, 8'd16};
            {5'h14, 6'h14}, {5'h17, 6'h17}: pos = {1'b1, 8'd16, 8'd32, 8'd48};
            {5'h15, 6'h15}, {5'h18, 6'h18}: pos = {1'b1, 8'd0, 8'd16, 8'd16};
            {5'h15, 6'h35}, {5'h18, 6'h38}: pos = {1'b1, 8'd0, 8'd0, 8'd0};
            {5'h19, 6'h19}: pos = {1'b1, 8'd24, 8'd48, 8'hFF};
            {5'h19, 6'h39}: pos = {1'b1, 8'd24, 8'd0, 8'd24};
            {5'h1A, 6'h1A}: pos = {1'b1, 8'd0, 8'd24, 8'd24};
            {5'h1A, 6'h3A}: pos = {1'b1, 8'd0, 8'd0, 8'd0};
            default: pos = '0;
        endcase
    end
    // Unused lanes follow the operands, never a stale copy
    always_comb begin
        al_o = {9{~a_i[7:0]}};
        bl_o = {9{a_i[7:0]}};
        ah_o = {9{~b_i[7:0]}};
        bh_o = {9{b_i[7:0]}};
        if (pos[24]) begin
            al_o[23:0] = a_i;
            bl_o[pos[23:16] +: 24] = b_i;
            ah_o[pos[15:8] +: 24] = c_i;
            if (pos[7:0] != 8'hFF) begin
                bh_o[pos[7:0] +: 24] = d_i;
            end
        end else begin
            al_o[71:64] = a_i[7:0];
            bl_o[71:64] = b_i[7:0];
            ah_o[71:64] = c_i[7:0];
            bh_o[71:64] = d_i[7:0];
        end
    end
endmodule : dols_fabric_drv

// ===== tb/tb_top.sv
`include "dols_defs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dols_pkg::*;
    // ********
    // Bench
    // ********
    localparam logic [23:0] op_a = 24'h3C1A81, op_b = 24'h41B2C4, op_c = 24'hC0D5E6, op_d = 24'h3E7F09;
    logic clk_i = 1'b0, reset_n_i, first_shared_exponent_enable_i, second_shared_exponent_enable_i;
    logic [4:0] lower_select_i;
    logic [5:0] upper_select_i;
    logic [2:0] first_mantissa_width_field_i, second_mantissa_width_field_i;
    logic [71:0] mult_a_low_i, mult_b_low_i, mult_a_high_i, mult_b_high_i;
    logic [7:0] side_exponent_i, shared_exp_ea_o, shared_exp_eb_o, shared_exp_ec_o, shared_exp_ed_o;
    logic [23:0] first_op_a_o, first_op_b_o, second_op_c_o, second_op_d_o;
    logic d_forced_one_o, narrow_exp_o, first_shared_mode_o, second_shared_mode_o, select_valid_o;
    dols_width_t first_width_o, second_width_o;
    dols_layout_t layout_o;
    // 03/23 straight into 09/29 so the back-to-back upper-code check is reached
    logic [10:0] sh_pair [19] = '{{5'h03, 6'h03}, {5'h03, 6'h23}, {5'h09, 6'h29}, {5'h04, 6'h04},
        {5'h04, 6'h24}, {5'h05, 6'h05}, {5'h05, 6'h25}, {5'h09, 6'h09}, {5'h1B, 6'h1B}, {5'h1C, 6'h1C},
        {5'h0D, 6'h0D}, {5'h0D, 6'h2D}, {5'h0E, 6'h0E}, {5'h0E, 6'h2E}, {5'h0F, 6'h0F}, {5'h10, 6'h10},
        {5'h11, 6'h11}, {5'h11, 6'h31}, {5'h12, 6'h12}};
    int errors = 0;
    int n_compared = 0;

    always #10 clk_i = ~clk_i;

    dols_lane_select dut (.clk_i, .reset_n_i, .lower_select_i, .upper_select_i, .first_shared_exponent_enable_i,
        .first_mantissa_width_field_i, .second_shared_exponent_enable_i, .second_mantissa_width_field_i,
        .mult_a_low_i, .mult_b_low_i, .mult_a_high_i, .mult_b_high_i, .side_exponent_i, .first_op_a_o,
        .first_op_b_o, .second_op_c_o, .second_op_d_o, .d_forced_one_o, .narrow_exp_o, .first_shared_mode_o,
        .second_shared_mode_o, .first_width_o, .second_width_o, .shared_exp_ea_o, .shared_exp_eb_o,
        .shared_exp_ec_o, .shared_exp_ed_o, .layout_o, .select_valid_o);
    dols_fabric_drv drv (.lower_i(lower_select_i), .upper_i(upper_select_i), .a_i(op_a), .b_i(op_b),
        .c_i(op_c), .d_i(op_d), .al_o(mult_a_low_i), .bl_o(mult_b_low_i), .ah_o(mult_a_high_i),
        .bh_o(mult_b_high_i));

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Result shows one edge after the pair is taken
    task automatic put(input logic [4:0] lo, input logic [5:0] hi);
        @(posedge clk_i);
        lower_select_i <= lo;
        upper_select_i <= hi;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask : put

    // Narrow operands sit in [23:8] with a zero low byte
    task automatic flt(input logic [4:0] lo, input logic [5:0] hi, input dols_layout_t ly, input logic fd, nw);
        logic w;
        w = (lo >= 5'h19);
        put(lo, hi);
        chk({17'h0, layout_o, d_forced_one_o, narrow_exp_o, select_valid_o}, {17'h0, ly, fd, nw, 1'b1});
        chk(first_op_a_o, w ? op_a : {op_a[15:0], 8'h00});
        chk(first_op_b_o, w ? op_b : {op_b[15:0], 8'h00});
        chk(second_op_c_o, w ? op_c : {op_c[15:0], 8'h00});
        chk(second_op_d_o, fd ? `DOLS_FP24_ONE : w ? op_d : {op_d[15:0], 8'h00});
    endtask : flt

    task automatic shr(input logic [4:0] lo, input logic [5:0] hi);
        logic sb;
        sb = (lo == 5'h04) || (lo == 5'h0E) || (lo == 5'h11);
        put(lo, hi);
        chk({shared_exp_ea_o, shared_exp_eb_o, shared_exp_ec_o},
            {op_a[7:0], sb ? side_exponent_i : op_b[7:0], op_c[7:0]});
        chk({11'h0, layout_o, select_valid_o, shared_exp_ed_o},
            {11'h0, DOLS_LAY_SHARED, 1'b1, (sb && hi[5]) ? side_exponent_i : op_d[7:0]});
    endtask : shr

    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        reset_n_i = 1'b0;
        lower_select_i = 5'h00;
        upper_select_i = 6'h00;
        first_shared_exponent_enable_i = 1'b0;
        second_shared_exponent_enable_i = 1'b0;
        first_mantissa_width_field_i = 3'b000;
        second_mantissa_width_field_i = 3'b000;
        side_exponent_i = 8'h5C;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(negedge clk_i);
        chk({11'h0, layout_o, select_valid_o, first_width_o, second_width_o, first_shared_mode_o,
            second_shared_mode_o}, 24'h0);
        flt(5'h13, 6'h13, DOLS_LAY_F16_ONE, 1'b1, 1'b0);
        flt(5'h13, 6'h33, DOLS_LAY_F16_SPL, 1'b0, 1'b0);
        flt(5'h14, 6'h14, DOLS_LAY_F16_X2, 1'b0, 1'b0);
        flt(5'h15, 6'h15, DOLS_LAY_F16_ALT, 1'b0, 1'b0);
        flt(5'h15, 6'h35, DOLS_LAY_F16_CMP, 1'b0, 1'b0);
        flt(5'h16, 6'h16, DOLS_LAY_F16_ONE, 1'b1, 1'b1);
        flt(5'h16, 6'h36, DOLS_LAY_F16_SPL, 1'b0, 1'b1);
        flt(5'h17, 6'h17, DOLS_LAY_F16_X2, 1'b0, 1'b1);
        flt(5'h18, 6'h18, DOLS_LAY_F16_ALT, 1'b0, 1'b1);
        flt(5'h18, 6'h38, DOLS_LAY_F16_CMP, 1'b0, 1'b1);
        flt(5'h19, 6'h39, DOLS_LAY_F24_SPL, 1'b0, 1'b0);
        flt(5'h1A, 6'h1A, DOLS_LAY_F24_X2, 1'b0, 1'b0);
        flt(5'h1A, 6'h3A, DOLS_LAY_F24_CMP, 1'b0, 1'b0);
        put(5'h13, 6'h19);
        chk(first_op_a_o | {19'h0, layout_o, select_valid_o}, 24'h0);
        foreach (sh_pair[i]) begin
            shr(sh_pair[i][10:6], sh_pair[i][5:0]);
        end
        flt(5'h19, 6'h19, DOLS_LAY_F24_ONE, 1'b1, 1'b0);
        for (int w = 0; w < 8; w++) begin
            @(posedge clk_i);
            first_mantissa_width_field_i <= 3'(w);
            second_mantissa_width_field_i <= 3'(7 - w);
            first_shared_exponent_enable_i <= w[0];
            second_shared_exponent_enable_i <= ~w[0];
            @(posedge clk_i);
            @(negedge clk_i);
            chk({18'h0, first_width_o, first_shared_mode_o, second_shared_mode_o, select_valid_o},
                {18'h0, (w == 2 || w == 5) ? 3'b000 : 3'(w), w[0], ~w[0], !(w == 2 || w == 5)});
            chk({21'h0, second_width_o}, {21'h0, (w == 2 || w == 5) ? 3'b000 : 3'(7 - w)});
        end
        close_out();
    end
endmodule : tb_top
